// ### rtl/speed_monitor_defs.svh
// constants of the dual channel speed monitor
`ifndef SPEED_MONITOR_DEFS_SVH
`define SPEED_MONITOR_DEFS_SVH

`define SM_CLK_HZ 100_000_000
`define SM_CYCLES_PER_MIN (64'd60 * 64'd100_000_000)
`define SM_STARTUP_MS 1500
`define SM_AGREE_MS 2000
`define SM_OPERATE_EXTRA_MS 2500
`define SM_RELEASE_LOW_MS 700
`define SM_RELEASE_HIGH_MS 350
`define SM_MIN_PULSE_US 1000
`define SM_FILTER_US (`SM_MIN_PULSE_US / 2)
`define SM_MAX_LPM 30000
`define SM_MS_CYCLES(ms) ((`SM_CLK_HZ / 1000) * (ms))
`define SM_US_CYCLES(us) ((`SM_CLK_HZ / 1_000_000) * (us))

// register offsets (byte addresses)
`define SM_REG_CTRL 8'h00
`define SM_REG_SET1 8'h04
`define SM_REG_SET2 8'h08
`define SM_REG_STATUS 8'h0C

// control fields
`define SM_CTRL_OVERSPEED 0
`define SM_CTRL_ADJUST 1
`define SM_CTRL_HIGH_RANGE 2
`define SM_CTRL_FIXED_LO 3
`define SM_CTRL_RESET 32'h0000_0000
// setting fields
`define SM_SET_SUB_LO 0
`define SM_SET_FINE_LO 8
`define SM_SET_RESET 32'h0000_8000

`endif

// ### rtl/speed_monitor_pkg.sv
// types of the dual channel speed monitor
package speed_monitor_pkg;
	typedef enum logic [2:0] {
		ST_STARTUP = 3'b000,
		ST_IDLE = 3'b001,
		ST_ARM = 3'b011,
		ST_RUN = 3'b010,
		ST_SPLIT = 3'b110,
		ST_LOCKOUT = 3'b100,
		ST_BLOCKED = 3'b101
	} monitor_state_t;
endpackage : speed_monitor_pkg

// ### rtl/pulse_filter.sv
// sensor input synchroniser, glitch filter and rising edge detect
`timescale 1ns/100ps
`default_nettype none
module pulse_filter #(
	parameter int FILTER_CYCLES = 50000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic rise_o
);
	logic sync_a;
	logic sync_b;
	logic level;
	logic next_level;
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic next_rise;

	always_ff @(posedge clk_i) begin
		sync_a <= pin_i;
		sync_b <= sync_a;
	end

	// a level must hold half the least pulse time to count
	always_comb begin
		next_level = level;
		next_cnt = 32'h0000_0000;
		next_rise = 1'b0;
		if (sync_b != level) begin
			next_cnt = cnt + 32'h0000_0001;
			if (cnt >= 32'(FILTER_CYCLES - 1)) begin
				next_level = sync_b;
				next_cnt = 32'h0000_0000;
				next_rise = sync_b;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level <= 1'b0;
			cnt <= 32'h0000_0000;
			rise_o <= 1'b0;
		end else begin
			level <= next_level;
			cnt <= next_cnt;
			rise_o <= next_rise;
		end
	end
endmodule : pulse_filter
`default_nettype wire

// ### rtl/rate_channel.sv
// one channel: edge interval timing and operate/release delays
`timescale 1ns/100ps
`default_nettype none
module rate_channel #(
	parameter int OPERATE_CYCLES = 250000000,
	parameter int RELEASE_LOW_CYCLES = 70000000,
	parameter int RELEASE_HIGH_CYCLES = 35000000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rise_i,
	input wire logic [39:0] thr_i,
	input wire logic overspeed_mode_i,
	input wire logic high_range_i,
	output logic below_o,
	output logic enable_o
);
	logic [39:0] cnt;
	logic [39:0] next_cnt;
	logic next_below;
	logic [31:0] dly;
	logic [31:0] next_dly;
	logic next_enable;
	logic [31:0] lim;

	always_comb begin
		next_cnt = cnt;
		next_below = below_o;
		if (rise_i) begin
			next_cnt = 40'h00_0000_0000;
			next_below = (cnt >= thr_i);
		end else if (cnt < thr_i) begin
			next_cnt = cnt + 40'h00_0000_0001;
		end else begin
			next_below = 1'b1;
		end
	end

	always_comb begin
		lim = 32'(OPERATE_CYCLES);
		if (overspeed_mode_i) begin
			lim = high_range_i ? 32'(RELEASE_HIGH_CYCLES)
				: 32'(RELEASE_LOW_CYCLES);
		end
		next_enable = enable_o;
		next_dly = 32'h0000_0000;
		if (enable_o != below_o) begin
			// operate is delayed in standstill mode, release in overspeed
			if (overspeed_mode_i == below_o) begin
				next_enable = below_o;
			end else begin
				next_dly = dly + 32'h0000_0001;
				if (dly >= lim - 32'h0000_0001) begin
					next_enable = below_o;
					next_dly = 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 40'h00_0000_0000;
			below_o <= 1'b0;
			dly <= 32'h0000_0000;
			enable_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			below_o <= next_below;
			dly <= next_dly;
			enable_o <= next_enable;
		end
	end
endmodule : rate_channel
`default_nettype wire

// ### rtl/dual_channel_speed_monitor.sv
// two-channel speed/standstill monitor with wishbone registers
`timescale 1ns/100ps
`default_nettype none
`include "speed_monitor_defs.svh"
module dual_channel_speed_monitor
	import speed_monitor_pkg::*;
#(
	parameter logic [63:0] CYCLES_PER_MIN = `SM_CYCLES_PER_MIN,
	parameter int STARTUP_CYCLES = `SM_MS_CYCLES(`SM_STARTUP_MS),
	// agreement window scales with the start-up time
	parameter int AGREE_CYCLES = int'(64'(STARTUP_CYCLES) * `SM_AGREE_MS
		/ `SM_STARTUP_MS),
	parameter int OPERATE_CYCLES = `SM_MS_CYCLES(`SM_OPERATE_EXTRA_MS),
	parameter int RELEASE_LOW_CYCLES = `SM_MS_CYCLES(`SM_RELEASE_LOW_MS),
	parameter int RELEASE_HIGH_CYCLES =
		RELEASE_LOW_CYCLES / (`SM_RELEASE_LOW_MS / `SM_RELEASE_HIGH_MS),
	parameter int FILTER_CYCLES = `SM_US_CYCLES(`SM_FILTER_US)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sensor_1_i,
	input wire logic sensor_2_i,
	input wire logic sensor_supply_ok_1_i,
	input wire logic sensor_supply_ok_2_i,
	input wire logic feedback_loop_terminal_b_i,
	output logic feedback_loop_terminal_a_o,
	output logic relay_drive_1_o,
	output logic relay_drive_2_o,
	output logic lamp_power_o,
	output logic lamp_ch1_o,
	output logic lamp_ch2_o
);
	////////////////////////////////////////////////////////////////////
	// rate table: lpm bounds, folded to periods at elaboration
	// 0..3 low build lower, 4..7 high build lower,
	// 8..15 the matching upper bounds, 16..19 fixed builds
	localparam int LPM_TBL [0:19] = '{
		8, 60, 450, 1800, 20, 120, 950, 3700,
		60, 450, 3600, 14000, 110, 900, 7000, 26000,
		15, 30, 60, 120};
	logic [39:0] per_tbl [0:19];

	genvar g;
	generate
		for (g = 0; g < 20; g++) begin : g_per
			assign per_tbl[g] = 40'(CYCLES_PER_MIN / 64'(LPM_TBL[g]));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// input synchronisers for supply sense and feedback loop
	logic [2:0] lvl_a;
	logic [2:0] lvl_b;
	logic [1:0] supply_ok;
	logic fb_closed;

	always_ff @(posedge clk_i) begin
		lvl_a <= {feedback_loop_terminal_b_i, sensor_supply_ok_2_i,
			sensor_supply_ok_1_i};
		lvl_b <= lvl_a;
	end
	assign supply_ok = lvl_b[1:0];
	assign fb_closed = lvl_b[2];

	////////////////////////////////////////////////////////////////////
	// wishbone slave: software config, latched at start-up
	logic [31:0] ctrl;
	logic [31:0] set1;
	logic [31:0] set2;
	logic [31:0] next_ctrl;
	logic [31:0] next_set1;
	logic [31:0] next_set2;
	logic [31:0] next_dat;
	logic next_ack;
	logic [31:0] lane_mask;
	logic [31:0] status;
	logic wr;

	monitor_state_t state;
	monitor_state_t next_state;
	logic [1:0] relay;
	logic [1:0] below;
	logic [1:0] ch_en;
	logic [31:0] act_ctrl;
	logic [31:0] act_set [0:1];

	always_comb begin
		lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
			{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
		next_ctrl = ctrl;
		next_set1 = set1;
		next_set2 = set2;
		if (wr && wb_adr_i == `SM_REG_CTRL) begin
			next_ctrl = (ctrl & ~lane_mask) | (wb_dat_i & lane_mask);
		end
		if (wr && wb_adr_i == `SM_REG_SET1) begin
			next_set1 = (set1 & ~lane_mask) | (wb_dat_i & lane_mask);
		end
		if (wr && wb_adr_i == `SM_REG_SET2) begin
			next_set2 = (set2 & ~lane_mask) | (wb_dat_i & lane_mask);
		end
		next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		unique case (wb_adr_i)
			`SM_REG_CTRL: next_dat = ctrl;
			`SM_REG_SET1: next_dat = set1;
			`SM_REG_SET2: next_dat = set2;
			`SM_REG_STATUS: next_dat = status;
			default: next_dat = 32'h0000_0000;
		endcase
		if (!next_ack || wb_we_i) begin
			next_dat = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `SM_CTRL_RESET;
			set1 <= `SM_SET_RESET;
			set2 <= `SM_SET_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			set1 <= next_set1;
			set2 <= next_set2;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	assign status = {20'h0_0000, state, below, relay, fb_closed,
		supply_ok, (state == ST_LOCKOUT), (state != ST_STARTUP)};

	////////////////////////////////////////////////////////////////////
	// per channel threshold and rate decision
	logic [1:0] rise;
	logic [1:0] sensor_pin;
	assign sensor_pin = {sensor_2_i, sensor_1_i};

	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic [2:0] idx;
			logic [39:0] per_lo;
			logic [39:0] per_hi;
			logic [47:0] span;
			logic [39:0] thr;

			// fine setting walks from the lower to the upper bound
			always_comb begin
				idx = {act_ctrl[`SM_CTRL_HIGH_RANGE],
					act_set[g][`SM_SET_SUB_LO +: 2]};
				per_lo = per_tbl[idx];
				per_hi = per_tbl[5'(idx) + 5'd8];
				span = 48'(per_lo - per_hi) *
					48'(act_set[g][`SM_SET_FINE_LO +: 8]);
				thr = per_lo - 40'(span >> 8);
				if (!act_ctrl[`SM_CTRL_ADJUST]) begin
					thr = per_tbl[5'(act_ctrl[`SM_CTRL_FIXED_LO +: 2])
						+ 5'd16];
				end
			end

			pulse_filter #(
				.FILTER_CYCLES(FILTER_CYCLES)
			) u_filter (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.pin_i(sensor_pin[g]),
				.rise_o(rise[g])
			);

			rate_channel #(
				.OPERATE_CYCLES(OPERATE_CYCLES),
				.RELEASE_LOW_CYCLES(RELEASE_LOW_CYCLES),
				.RELEASE_HIGH_CYCLES(RELEASE_HIGH_CYCLES)
			) u_rate (
				.clk_i(clk_i),
				.rst_i(rst_i | (state == ST_STARTUP)),
				.rise_i(rise[g]),
				.thr_i(thr),
				.overspeed_mode_i(act_ctrl[`SM_CTRL_OVERSPEED]),
				.high_range_i(act_ctrl[`SM_CTRL_HIGH_RANGE]),
				.below_o(below[g]),
				.enable_o(ch_en[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// start-up, agreement and lockout sequencing
	logic [31:0] tmr;
	logic [31:0] next_tmr;
	logic [1:0] en_ok;
	logic [1:0] next_relay;
	logic [31:0] next_act_ctrl;
	logic [31:0] next_act_set [0:1];

	// a lost sensor supply removes that channel at once
	assign en_ok = ch_en & supply_ok;

	always_comb begin
		next_state = state;
		next_tmr = tmr + 32'h0000_0001;
		next_relay = 2'b00;
		next_act_ctrl = act_ctrl;
		next_act_set[0] = act_set[0];
		next_act_set[1] = act_set[1];
		unique case (state)
			ST_STARTUP: begin
				if (tmr >= 32'(STARTUP_CYCLES - 1)) begin
					next_tmr = 32'h0000_0000;
					next_act_ctrl = ctrl;
					next_act_set[0] = set1;
					next_act_set[1] = set2;
					next_state = fb_closed ? ST_IDLE : ST_LOCKOUT;
				end
			end
			ST_IDLE: begin
				next_tmr = 32'h0000_0000;
				// open loop means external contacts still welded
				if (fb_closed && en_ok == 2'b11) begin
					next_state = ST_RUN;
					next_relay = 2'b11;
				end else if (fb_closed && en_ok != 2'b00) begin
					next_state = ST_ARM;
				end
			end
			ST_ARM: begin
				if (en_ok == 2'b11) begin
					next_state = ST_RUN;
					next_relay = 2'b11;
				end else if (en_ok == 2'b00) begin
					next_state = ST_IDLE;
				end else if (tmr >= 32'(AGREE_CYCLES - 1)) begin
					next_state = ST_BLOCKED;
				end
			end
			ST_RUN: begin
				next_tmr = 32'h0000_0000;
				next_relay = en_ok;
				if (en_ok == 2'b00) begin
					next_state = ST_IDLE;
				end else if (en_ok != 2'b11) begin
					next_state = ST_SPLIT;
				end
			end
			ST_SPLIT: begin
				// a dropped channel may not come back on its own
				next_relay = relay & en_ok;
				if (next_relay == 2'b00) begin
					next_state = ST_IDLE;
				end else if (tmr >= 32'(AGREE_CYCLES - 1)) begin
					next_state = ST_LOCKOUT;
					next_relay = 2'b00;
				end
			end
			ST_BLOCKED: begin
				if (en_ok == 2'b00) begin
					next_state = ST_IDLE;
				end
			end
			ST_LOCKOUT: begin
				next_tmr = 32'h0000_0000;
			end
			default: begin
				next_state = ST_LOCKOUT;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_STARTUP;
			tmr <= 32'h0000_0000;
			relay <= 2'b00;
			act_ctrl <= `SM_CTRL_RESET;
			act_set[0] <= `SM_SET_RESET;
			act_set[1] <= `SM_SET_RESET;
			relay_drive_1_o <= 1'b0;
			relay_drive_2_o <= 1'b0;
			lamp_ch1_o <= 1'b0;
			lamp_ch2_o <= 1'b0;
			lamp_power_o <= 1'b0;
			feedback_loop_terminal_a_o <= 1'b0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			relay <= next_relay;
			act_ctrl <= next_act_ctrl;
			act_set[0] <= next_act_set[0];
			act_set[1] <= next_act_set[1];
			relay_drive_1_o <= next_relay[0];
			relay_drive_2_o <= next_relay[1];
			// channel lamp is on exactly when its relay drive is on
			lamp_ch1_o <= next_relay[0];
			lamp_ch2_o <= next_relay[1];
			lamp_power_o <= 1'b1;
			feedback_loop_terminal_a_o <= 1'b1;
		end
	end
endmodule : dual_channel_speed_monitor
`default_nettype wire

// ### testbench/speed_monitor_monitor.sv
// assertion checker on the speed monitor's ports
`timescale 1ns/100ps
`default_nettype none
module speed_monitor_monitor #(
	parameter int STARTUP_CYCLES = 100
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic sensor_supply_ok_1_i,
	input wire logic sensor_supply_ok_2_i,
	input wire logic feedback_loop_terminal_a_o,
	input wire logic relay_drive_1_o,
	input wire logic relay_drive_2_o,
	input wire logic lamp_power_o,
	input wire logic lamp_ch1_o,
	input wire logic lamp_ch2_o
);
	int up;
	int next_up;
	// saturates, so long runs never wrap it
	always_comb begin
		next_up = up < STARTUP_CYCLES ? up + 1 : up;
	end
	always_ff @(posedge clk_i) begin
		up <= rst_i ? 0 : next_up;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	property p_startup;
		up < STARTUP_CYCLES |-> !relay_drive_1_o && !relay_drive_2_o;
	endproperty
	a_startup: assert property (p_startup)
		else $error("relay on in start-up");
	property p_reset;
		$past(rst_i) |-> !relay_drive_1_o && !relay_drive_2_o && !lamp_power_o;
	endproperty
	a_reset: assert property (p_reset)
		else $error("output set out of reset");
	property p_power;
		!$past(rst_i) |-> lamp_power_o && feedback_loop_terminal_a_o;
	endproperty
	a_power: assert property (p_power)
		else $error("power lamp or loop drive off");
	property p_lamps;
		lamp_ch1_o == relay_drive_1_o && lamp_ch2_o == relay_drive_2_o;
	endproperty
	a_lamps: assert property (p_lamps)
		else $error("lamp differs from relay");
	property p_supply_1;
		!sensor_supply_ok_1_i [*4] |-> !relay_drive_1_o;
	endproperty
	a_supply_1: assert property (p_supply_1)
		else $error("relay 1 on without supply");
	property p_supply_2;
		!sensor_supply_ok_2_i [*4] |-> !relay_drive_2_o;
	endproperty
	a_supply_2: assert property (p_supply_2)
		else $error("relay 2 on without supply");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack not a one cycle answer");
	property p_ack_cause;
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_dat;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat: assert property (p_dat)
		else $error("read data outside ack");
endmodule : speed_monitor_monitor
bind dual_channel_speed_monitor speed_monitor_monitor #(
	.STARTUP_CYCLES(STARTUP_CYCLES)
) mon (.*);
`default_nettype wire

// ### testbench/sensor_loop_model.sv
// two pulse sensors and the external feedback contact loop
`timescale 1ns/100ps
`default_nettype none
module sensor_loop_model (
	input wire logic clk_i,
	input wire logic [31:0] period_1_i,
	input wire logic [31:0] period_2_i,
	input wire logic loop_closed_i,
	input wire logic feedback_loop_terminal_a_i,
	output logic sensor_1_o,
	output logic sensor_2_o,
	output logic feedback_loop_terminal_b_o
);
	logic [31:0] ph_1 = 32'h0000_0000;
	logic [31:0] ph_2 = 32'h0000_0000;
	// closed contacts only return the excitation, never a level of their own
	assign feedback_loop_terminal_b_o = loop_closed_i
		& feedback_loop_terminal_a_i;
	always @(posedge clk_i) begin
		ph_1 <= (period_1_i == 0 || ph_1 + 1 >= period_1_i) ? 0 : ph_1 + 1;
		ph_2 <= (period_2_i == 0 || ph_2 + 1 >= period_2_i) ? 0 : ph_2 + 1;
	end
	// a period of zero is a stopped target: sensor output stays low
	assign sensor_1_o = period_1_i != 0 && ph_1 < period_1_i / 2;
	assign sensor_2_o = period_2_i != 0 && ph_2 < period_2_i / 2;
endmodule : sensor_loop_model
`default_nettype wire

// ### testbench/dual_channel_speed_monitor_tb_top.sv
// self-checking bench for the dual channel speed monitor
`timescale 1ns/100ps
`default_nettype none
module dual_channel_speed_monitor_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic ok_1 = 1'b1;
	logic ok_2 = 1'b1;
	logic closed = 1'b1;
	logic [31:0] per_1 = 32'h0000_0000;
	logic [31:0] per_2 = 32'h0000_0000;
	logic [31:0] rd;
	logic [31:0] v;
	wire logic [31:0] rdat;
	wire logic ack, s_1, s_2, fb_a, fb_b, rly_1, rly_2, lp, l1, l2;
	int miscompares = 0;
	int checked = 0;
	int seed = 10102;
	int n;
	always #5 clk = ~clk;
	// short counts: threshold at 120 per minute is 5000 cycles
	// agreement window follows as 133 cycles, fast release as 15
	dual_channel_speed_monitor #(
		.CYCLES_PER_MIN(64'h0000_0000_0009_27c0), .STARTUP_CYCLES(100),
		.OPERATE_CYCLES(50), .RELEASE_LOW_CYCLES(30), .FILTER_CYCLES(5)
	) uut (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sensor_1_i(s_1), .sensor_2_i(s_2),
		.sensor_supply_ok_1_i(ok_1), .sensor_supply_ok_2_i(ok_2),
		.feedback_loop_terminal_b_i(fb_b), .feedback_loop_terminal_a_o(fb_a),
		.relay_drive_1_o(rly_1), .relay_drive_2_o(rly_2), .lamp_power_o(lp),
		.lamp_ch1_o(l1), .lamp_ch2_o(l2)
	);
	sensor_loop_model far (
		.clk_i(clk), .period_1_i(per_1), .period_2_i(per_2),
		.loop_closed_i(closed), .feedback_loop_terminal_a_i(fb_a),
		.sensor_1_o(s_1), .sensor_2_o(s_2), .feedback_loop_terminal_b_o(fb_b)
	);
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkb(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp});
	endtask : chkb
	// threshold period on the low build's top subrange, linear in period
	function automatic int adj_thr(input int fine);
		int lo;
		int hi;
		lo = 600000 / 1800;
		hi = 600000 / 14000;
		return lo - (lo - hi) * fine / 256;
	endfunction : adj_thr
	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		// no cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic wait_rly(input logic [1:0] e, input logic [1:0] m,
			input int lim);
		n = 0;
		while (({rly_1, rly_2} & m) !== e && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_rly
	// power cycle; settings only count if written before start-up ends
	task automatic boot(input logic [31:0] ctrl, input logic fb);
		@(posedge clk);
		rst <= 1'b1;
		per_1 <= 32'h0000_0000;
		per_2 <= 32'h0000_0000;
		ok_1 <= 1'b1;
		ok_2 <= 1'b1;
		closed <= fb;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		wb(1'b1, 8'h00, ctrl, 4'hf);
	endtask : boot
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////
	initial begin
		boot(32'h0000_0000, 1'b1);
		wb(1'b0, 8'h00, 32'h0000_0000, 4'hf);
		chk(rd, 32'h0000_0000);
		for (int i = 4; i < 12; i += 4) begin
			wb(1'b0, i[7:0], 32'h0000_0000, 4'hf);
			chk(rd, 32'h0000_8000);
			v = $random(seed) & 32'h0000_ff03;
			wb(1'b1, i[7:0], v, 4'hf);
			wb(1'b1, i[7:0], 32'hffff_ffff, 4'h1);
			wb(1'b0, i[7:0], 32'h0000_0000, 4'hf);
			chk(rd, (v & 32'h0000_ff00) | 32'h0000_00ff);
		end
		wb(1'b1, 8'h10, $random(seed), 4'hf);
		wb(1'b0, 8'h10, 32'h0000_0000, 4'hf);
		chk(rd, 32'h0000_0000);
		wb(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
		wb(1'b0, 8'h0c, 32'h0000_0000, 4'hf);
		chk(rd & 32'h0000_007f, 32'h0000_001c);
		boot(32'h0000_0018, 1'b1);
		wait_rly(2'b11, 2'b11, 6000);
		chkb({1'b0, n >= 5040 && n <= 5250}, 2'b01);
		chkb({l1, l2}, 2'b11);
		chkb({lp, fb_a}, 2'b11);
		v = 32'h0000_0014 + ($random(seed) & 32'h0000_07ff);
		per_1 <= v;
		per_2 <= v;
		wait_rly(2'b00, 2'b11, 6000);
		chkb({rly_1, rly_2}, 2'b00);
		chkb({l1, l2}, 2'b00);
		per_1 <= 32'h0000_0000;
		per_2 <= 32'h0000_0000;
		wait_rly(2'b11, 2'b11, 6000);
		chkb({rly_1, rly_2}, 2'b11);
		ok_1 <= 1'b0;
		repeat (5) @(posedge clk);
		chkb({rly_1, rly_2}, 2'b01);
		repeat (250) @(posedge clk);
		chkb({rly_1, rly_2}, 2'b00);
		ok_1 <= 1'b1;
		repeat (6000) @(posedge clk);
		chkb({rly_1, rly_2}, 2'b00);
		wb(1'b0, 8'h0c, 32'h0000_0000, 4'hf);
		chkb({1'b0, rd[1]}, 2'b01);
		for (int h = 0; h < 2; h++) begin
			boot(32'h0000_0019 | (h << 2), 1'b1);
			wait_rly(2'b11, 2'b11, 6000);
			chkb({l1, l2}, 2'b11);
			per_1 <= 32'h0000_03e8;
			per_2 <= 32'h0000_03e8;
			wait_rly(2'b00, 2'b11, 2000);
			v = h ? 15 : 30;
			chkb({1'b0, n >= 1000 + v && n <= 1022 + v}, 2'b01);
			chkb({l1, l2}, 2'b00);
		end
		boot(32'h0000_0019, 1'b1);
		wait_rly(2'b11, 2'b11, 6000);
		per_1 <= 32'h0000_03e8;
		wait_rly(2'b00, 2'b10, 2000);
		chkb({rly_1, rly_2}, 2'b01);
		repeat (250) @(posedge clk);
		chkb({rly_1, rly_2}, 2'b00);
		per_1 <= 32'h0000_0000;
		repeat (6000) @(posedge clk);
		chkb({rly_1, rly_2}, 2'b00);
		boot(32'h0000_0002, 1'b1);
		v = 32'h0000_0003 | ($random(seed) & 32'h0000_ff00);
		wb(1'b1, 8'h04, v, 4'hf);
		wb(1'b1, 8'h08, v, 4'hf);
		wait_rly(2'b11, 2'b11, 2000);
		n -= adj_thr(int'(v[15:8]));
		chkb({1'b0, n >= 140 && n <= 150}, 2'b01);
		boot(32'h0000_0018, 1'b0);
		repeat (6000) @(posedge clk);
		chkb({rly_1, rly_2}, 2'b00);
		boot(32'h0000_0018, 1'b1);
		ok_2 <= 1'b0;
		repeat (6000) @(posedge clk);
		chkb({rly_1, rly_2}, 2'b00);
		tally_and_finish();
	end
	// about 60000 cycles are needed; this leaves margin
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
endmodule : dual_channel_speed_monitor_tb_top
`default_nettype wire
